// ### rtl/pwoc_defs.vh
// Constants for the output-control stage of one modulator channel.
// Included by the top-level design file; definitions only.
`ifndef PWOC_DEFS_VH
`define PWOC_DEFS_VH

// Register byte offsets
`define PWOC_OFS_CTRL      4'h0
`define PWOC_OFS_KEY       4'h4
`define PWOC_OFS_STATUS    4'h8
`define PWOC_OFS_RUN       4'hC

// Control register fields
`define PWOC_LIMIT_MODE    24
`define PWOC_LSRC_HI       31
`define PWOC_LSRC_LO       28
`define PWOC_FSRC_HI       23
`define PWOC_FSRC_LO       20
`define PWOC_FMODE_HI      17
`define PWOC_FMODE_LO      16
`define PWOC_OWN_HIGH      15
`define PWOC_OWN_LOW       14
`define PWOC_POL_HIGH      13
`define PWOC_POL_LOW       12
`define PWOC_OVR_HIGH_EN   9
`define PWOC_OVR_LOW_EN    8
`define PWOC_OVR_DAT_LO    6
`define PWOC_FLT_DAT_LO    4
`define PWOC_LIM_DAT_LO    2
`define PWOC_SWAP          1
`define PWOC_CTRL_MASK     32'hF1F3F3FE
`define PWOC_CTRL_RST      32'h00000000

// Unlock keys, compared on the low half-word
`define PWOC_KEY_FIRST     16'hABCD
`define PWOC_KEY_SECOND    16'h4321

`endif

// ### rtl/pwoc_pin_mux.v
// Per-pin state selection: fault, current limit, override, modulation.
// Inputs are all on sys_clk; output is combinational and registered by the caller.
`timescale 1ns/1ns

module pwoc_pin_mux (
    // Generated modulation level (active state)
    input  wire pwm_act,
    // Override request and data
    input  wire ovr_en,
    input  wire ovr_dat,
    // Fault request and data
    input  wire flt_act,
    input  wire flt_dat,
    // Current-limit request and data
    input  wire lim_act,
    input  wire lim_dat,
    // Polarity: 1 makes the active state a low level
    input  wire pol,
    // Resulting pin level
    output reg  pin_lvl
);

    reg state;

    // Fault beats limit beats override; inactive sources never reach the pin
    always @* begin
        if (flt_act) begin
            state = flt_dat; // RQ3
        end else if (lim_act) begin
            state = lim_dat; // RQ6
        end else if (ovr_en) begin
            state = ovr_dat; // RQ1
        end else begin
            state = pwm_act; // RQ4 RQ7
        end
        pin_lvl = state ^ pol; // RQ10
    end

endmodule

// ### rtl/pwoc_top.v
// Output-control stage of one modulator channel with Avalon-MM registers.
// Assumes a single sys_clk domain; fault inputs and the lock fuse are async pins.
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "pwoc_defs.vh"

// Function
// RQ1: Override enables route override data to pins
// RQ2: Fault mode enabled when field is 00/01
// RQ3: Active fault drives fault data to pins
// RQ4: Fault data ignored while no fault
// RQ5: Limit mode enabled by bit 24
// RQ6: Active limit drives limit data to pins
// RQ7: Limit data ignored while no limit
// RQ8: Swap set exchanges high and low signals
// RQ9: Swap clear keeps signals on own pins
// RQ10: Data is active state, polarity sets level
// RQ11: Fuse low locks control writes behind key
// RQ12: Writer sends two keys back to back
// RQ13: Protected write must be next access
// RQ14: No other access inside unlock sequence
// RQ15: Fault data fixed once time base runs
// RQ16: Ownership bits alone decide pin control
// RQ17: Set ownership before enabling time base
// RQ18: Fault and limit sources from 15 inputs
// RQ19: Lock re-engages after one protected write
module pwoc_top #(
    parameter NUM_SRC = 15
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        arst_n,
    // Avalon-MM slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Modulation from the time base, same clock
    input  wire        pwm_high_in,
    input  wire        pwm_low_in,
    // Port-module drive used while the pins are not owned
    input  wire        gpio_high_data,
    input  wire        gpio_high_oe,
    input  wire        gpio_low_data,
    input  wire        gpio_low_oe,
    // Asynchronous fault / limit inputs and lock fuse
    input  wire [NUM_SRC:1] fault_in,
    input  wire        config_write_lock_fuse,
    // Pins and time-base enable
    output reg         high_output_pin,
    output reg         high_output_oe,
    output reg         low_output_pin,
    output reg         low_output_oe,
    output wire        timebase_enable
);

    // Unlock sequence states
    localparam [1:0] LK_IDLE = 2'b00;
    localparam [1:0] LK_KEY1 = 2'b01;
    localparam [1:0] LK_OPEN = 2'b10;

    // Flops and next values
    reg  [31:0]      ctrl_q;
    reg              run_q;
    reg  [1:0]       lk_q;
    reg  [1:0]       lk_d;
    reg              ack_q;
    reg  [NUM_SRC:1] flt_s1_q;
    reg  [NUM_SRC:1] flt_s2_q;
    reg              fuse_s1_q;
    reg              fuse_s2_q;

    // Combinational helpers
    reg  [31:0]      rd_d;
    reg  [31:0]      wmask;
    reg  [31:0]      ctrl_d;
    reg              flt_src;
    reg              lim_src;

    // Bus strobes and decoded control fields
    wire             req;
    wire             done;
    wire             key_wr;
    wire             ctrl_wr;
    wire             write_ok;
    wire             flt_mode;
    wire             lim_mode;
    wire             flt_act;
    wire             lim_act;
    wire [1:0]       pwm_sel;
    wire [1:0]       pol;
    wire [1:0]       ovr_en;
    wire [1:0]       lvl;
    wire [3:0]       fsel;
    wire [3:0]       lsel;

    // One wait cycle per access; completion is the edge with ack_q high
    // A fixed wait costs a cycle per access but keeps read data registered
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign done            = req & ack_q;

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Two-flop synchronisers for asynchronous pins
    // Reset to inactive so no false fault is seen as reset releases
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flt_s1_q  <= {NUM_SRC{1'b0}};
            flt_s2_q  <= {NUM_SRC{1'b0}};
            fuse_s1_q <= 1'b0;
            fuse_s2_q <= 1'b0;
        end else begin
            flt_s1_q  <= fault_in;
            flt_s2_q  <= flt_s1_q;
            fuse_s1_q <= config_write_lock_fuse;
            fuse_s2_q <= fuse_s1_q;
        end
    end

    // Completed writes to the key and control words
    assign key_wr  = done & avs_write & (avs_address == `PWOC_OFS_KEY)
                     & (avs_byteenable[1:0] == 2'b11);
    assign ctrl_wr = done & avs_write & (avs_address == `PWOC_OFS_CTRL);

    // Fuse high leaves the control register open; fuse low needs the key.
    // The fuse synchroniser resets to 0, so for two edges after reset the
    // register counts as locked, the safe side while the fuse is unknown.
    assign write_ok = fuse_s2_q | (lk_q == LK_OPEN); // RQ11 RQ13

    // Key sequencer: after the first key every completed access moves it on, so any access
    // between the keys or before the protected write breaks the sequence
    always @* begin
        lk_d = lk_q;
        if (done) begin
            case (lk_q)
                LK_IDLE: begin
                    if (key_wr && avs_writedata[15:0] == `PWOC_KEY_FIRST) begin
                        lk_d = LK_KEY1; // RQ12
                    end
                end
                LK_KEY1: begin
                    if (key_wr && avs_writedata[15:0] == `PWOC_KEY_SECOND) begin
                        lk_d = LK_OPEN; // RQ12
                    end else begin
                        lk_d = LK_IDLE; // RQ14
                    end
                end
                LK_OPEN: begin
                    lk_d = LK_IDLE; // RQ13 RQ19
                end
                default: begin
                    lk_d = LK_IDLE;
                end
            endcase
        end
    end

    // Sequencer state; reset closes any open window
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lk_q <= LK_IDLE;
        end else begin
            lk_q <= lk_d;
        end
    end

    // Byte-enable merge into the control word; reserved bits stay zero
    always @* begin
        wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        ctrl_d = ((ctrl_q & ~wmask) | (avs_writedata & wmask)) & `PWOC_CTRL_MASK;
    end

    // Control and run registers; the run bit is not protected
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `PWOC_CTRL_RST;
            run_q  <= 1'b0;
        end else begin
            if (ctrl_wr && write_ok) begin
                ctrl_q <= ctrl_d; // RQ11
            end
            if (done && avs_write && avs_address == `PWOC_OFS_RUN
                && avs_byteenable[0]) begin
                run_q <= avs_writedata[0];
            end
        end
    end

    // Time-base enable comes straight from the run flop
    assign timebase_enable = run_q;

    // Source selection: code n picks input n, code 0 picks none
    // One input may feed both fault and limit; the fault then wins
    assign fsel = ctrl_q[`PWOC_FSRC_HI:`PWOC_FSRC_LO];
    assign lsel = ctrl_q[`PWOC_LSRC_HI:`PWOC_LSRC_LO];

    always @* begin
        flt_src = 1'b0;
        lim_src = 1'b0;
        if (fsel != 4'h0) begin
            flt_src = flt_s2_q[fsel]; // RQ18
        end
        if (lsel != 4'h0) begin
            lim_src = flt_s2_q[lsel]; // RQ18
        end
    end

    // Mode codes 00 and 01 enable faults, so only the upper bit matters;
    // faults and limits are levels and release the pins when they clear
    assign flt_mode = ~ctrl_q[`PWOC_FMODE_HI]; // RQ2
    assign lim_mode = ctrl_q[`PWOC_LIMIT_MODE]; // RQ5
    assign flt_act  = flt_mode & flt_src;
    assign lim_act  = lim_mode & lim_src;

    // Index 1 is the high side, index 0 the low side
    assign pwm_sel[1] = ctrl_q[`PWOC_SWAP] ? pwm_low_in : pwm_high_in; // RQ8 RQ9
    assign pwm_sel[0] = ctrl_q[`PWOC_SWAP] ? pwm_high_in : pwm_low_in; // RQ8 RQ9
    assign pol        = {ctrl_q[`PWOC_POL_HIGH], ctrl_q[`PWOC_POL_LOW]};
    assign ovr_en     = {ctrl_q[`PWOC_OVR_HIGH_EN], ctrl_q[`PWOC_OVR_LOW_EN]};

    // One selector per pin
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            pwoc_pin_mux u_mux (
                .pwm_act (pwm_sel[gi]),
                .ovr_en  (ovr_en[gi]),
                .ovr_dat (ctrl_q[`PWOC_OVR_DAT_LO + gi]), // RQ1
                .flt_act (flt_act),
                .flt_dat (ctrl_q[`PWOC_FLT_DAT_LO + gi]), // RQ3 RQ4
                .lim_act (lim_act),
                .lim_dat (ctrl_q[`PWOC_LIM_DAT_LO + gi]), // RQ6 RQ7
                .pol     (pol[gi]), // RQ10
                .pin_lvl (lvl[gi])
            );
        end
    endgenerate

    // Pin registers: unowned pins stay with the port module
    // Registering here keeps selector glitches away from the gate driver
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            high_output_pin <= 1'b0;
            high_output_oe  <= 1'b0;
            low_output_pin  <= 1'b0;
            low_output_oe   <= 1'b0;
        end else begin
            if (ctrl_q[`PWOC_OWN_HIGH]) begin
                high_output_pin <= lvl[1];
                high_output_oe  <= 1'b1;
            end else begin
                high_output_pin <= gpio_high_data; // RQ16
                high_output_oe  <= gpio_high_oe; // RQ16
            end
            if (ctrl_q[`PWOC_OWN_LOW]) begin
                low_output_pin <= lvl[0];
                low_output_oe  <= 1'b1;
            end else begin
                low_output_pin <= gpio_low_data; // RQ16
                low_output_oe  <= gpio_low_oe; // RQ16
            end
        end
    end

    // Read mux; key register and unmapped words read as zero
    always @* begin
        rd_d = 32'h00000000;
        case (avs_address)
            `PWOC_OFS_CTRL: begin
                rd_d = ctrl_q;
            end
            `PWOC_OFS_STATUS: begin
                rd_d = {26'h0000000, low_output_pin, high_output_pin,
                        fuse_s2_q, (lk_q == LK_OPEN), lim_act, flt_act};
            end
            `PWOC_OFS_RUN: begin
                rd_d = {31'h00000000, run_q};
            end
            default: begin
                rd_d = 32'h00000000;
            end
        endcase
    end

    // Read data loaded during the wait cycle so it stands at completion
    // Loading only on the wait edge keeps it steady until the next read
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack_q) begin
            avs_readdata <= rd_d;
        end
    end

endmodule

// ### testbench/pwoc_top_assertions.sv
// Port-level checker for the output-control stage.
// Assumes the single sys_clk domain and asynchronous active-low arst_n.
`timescale 1ns/1ns

module pwoc_top_assertions (
    // Clock and reset
    input wire        sys_clk,
    input wire        arst_n,
    // Register bus
    input wire [3:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // Port drive and pins
    input wire        gpio_high_data,
    input wire        gpio_high_oe,
    input wire        gpio_low_data,
    input wire        gpio_low_oe,
    input wire        high_output_pin,
    input wire        high_output_oe,
    input wire        low_output_pin,
    input wire        low_output_oe,
    input wire        timebase_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // Completed access and first control write since reset
    wire done = !avs_waitrequest && (avs_read || avs_write);
    reg  ctrl_wr_q;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            ctrl_wr_q <= 1'h0;
        else if (done && avs_write && avs_address == 4'h0)
            ctrl_wr_q <= 1'h1;
    end

    AST_WAIT_FIRST: assert property (
        $rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait cycle");
    AST_ONE_WAIT: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    AST_KEY_READ0: assert property (
        done && avs_read && avs_address == 4'h4 |-> avs_readdata == 32'h0)
        else $error("key readable");
    AST_STAT_RSVD: assert property (
        done && avs_read && avs_address == 4'h8 |-> avs_readdata[31:6] == 26'h0)
        else $error("status reserved bits");
    AST_RDATA_HOLD: assert property (
        !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved");
    AST_RUN_WR: assert property (
        done && avs_write && avs_address == 4'hC && avs_byteenable[0]
        |=> timebase_enable == $past(avs_writedata[0]))
        else $error("run write lost");
    AST_RUN_HOLD: assert property (
        !(done && avs_write && avs_address == 4'hC) |=> $stable(timebase_enable))
        else $error("run changed");
    // Until ownership can be set, the pins stay with the port drive one edge later
    AST_GPIO_PASS: assert property (
        !ctrl_wr_q |=> high_output_oe == $past(gpio_high_oe)
            && low_output_oe == $past(gpio_low_oe)
            && (high_output_pin & high_output_oe) == ($past(gpio_high_data) & $past(gpio_high_oe))
            && (low_output_pin & low_output_oe) == ($past(gpio_low_data) & $past(gpio_low_oe)))
        else $error("port drive lost");
endmodule

bind pwoc_top pwoc_top_assertions u_chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .gpio_high_data(gpio_high_data),
    .gpio_high_oe(gpio_high_oe), .gpio_low_data(gpio_low_data), .gpio_low_oe(gpio_low_oe),
    .high_output_pin(high_output_pin), .high_output_oe(high_output_oe),
    .low_output_pin(low_output_pin), .low_output_oe(low_output_oe),
    .timebase_enable(timebase_enable));

// ### testbench/pwoc_gate_stage.sv
// Behavioural power stage fed by the two output pins.
// Assumes pull-downs on both gate inputs.
`timescale 1ns/1ns

module pwoc_gate_stage (
    // Pins from the block
    input  wire       high_output_pin,
    input  wire       high_output_oe,
    input  wire       low_output_pin,
    input  wire       low_output_oe,
    // Gate commands, high side first
    output wire [1:0] gate_cmd
);
    // A released pin falls to its pull-down rather than keeping its last level
    assign gate_cmd = {high_output_oe & high_output_pin, low_output_oe & low_output_pin};
endmodule

// ### testbench/pwoc_top_tb.sv
// Self-checking bench for the output-control stage.
// Drives the register bus, modulation, port drive, fault inputs and fuse.
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module pwoc_top_tb;
    reg         sys_clk = 1'h0;
    reg         arst_n = 1'h0;
    reg  [3:0]  avs_address = 4'h0;
    reg         avs_read = 1'h0;
    reg         avs_write = 1'h0;
    reg  [31:0] avs_writedata = 32'h0;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    reg  [1:0]  pwm = 2'h0;
    reg  [3:0]  gpio = 4'h0;
    reg  [15:1] fault_in = 15'h0;
    reg         fuse = 1'h1;
    wire        hp, ho, lp, lo, tben;
    wire [1:0]  gate;
    reg  [31:0] rd;
    integer     n_mismatch = 0;
    integer     num_checks = 0;
    integer     i;

    pwoc_top u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pwm_high_in(pwm[1]), .pwm_low_in(pwm[0]), .gpio_high_data(gpio[3]),
        .gpio_high_oe(gpio[2]), .gpio_low_data(gpio[1]), .gpio_low_oe(gpio[0]),
        .fault_in(fault_in), .config_write_lock_fuse(fuse), .high_output_pin(hp),
        .high_output_oe(ho), .low_output_pin(lp), .low_output_oe(lo), .timebase_enable(tben));

    pwoc_gate_stage u_stage (.high_output_pin(hp), .high_output_oe(ho),
        .low_output_pin(lp), .low_output_oe(lo), .gate_cmd(gate));

    // Clock
    always #20 sys_clk = ~sys_clk;

    // One bus access; request held until waitrequest is seen low at an edge
    task acc(input w, input [3:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= w;
            avs_read <= !w;
            @(posedge sys_clk);
            while (avs_waitrequest) @(posedge sys_clk);
            rd = avs_readdata;
            avs_write <= 1'h0;
            avs_read <= 1'h0;
        end
    endtask

    // Pins settle within sync plus register edges
    task pins(input [1:0] e);
        begin
            repeat (4) @(posedge sys_clk);
            @(negedge sys_clk);
            `CHK(gate, e)
        end
    endtask

    task stat(input e);
        begin
            repeat (3) @(posedge sys_clk);
            acc(1'h0, 4'h8, 32'h0);
            `CHK(rd[0], e)
        end
    endtask

    task chk_ctrl(input [31:0] e);
        begin
            acc(1'h0, 4'h0, 32'h0);
            `CHK(rd, e)
        end
    endtask

    task unlock;
        begin
            acc(1'h1, 4'h4, 32'h0000ABCD);
            acc(1'h1, 4'h4, 32'h00004321);
        end
    endtask

    task finish_test;
        begin
            if (n_mismatch == 0 && num_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge sys_clk);
        gpio <= 4'hE;
        pins(2'h2);
        chk_ctrl(32'h0);
        `CHK(tben, 1'h0)
        pwm <= 2'h2;
        acc(1'h1, 4'h0, 32'h0000C000);
        pins(2'h2);
        acc(1'h1, 4'h0, 32'h0000C002);
        pins(2'h1);
        acc(1'h1, 4'h0, 32'h0000C340);
        pins(2'h1);
        acc(1'h1, 4'h0, 32'h0000C240);
        pins(2'h0);
        acc(1'h1, 4'h0, 32'h0000F340);
        pins(2'h2);
        // Fault on input 3 across all four mode codes
        fault_in <= 15'h0004;
        for (i = 0; i < 4; i = i + 1) begin
            acc(1'h1, 4'h0, 32'h0030C010 | (i << 16));
            pins((i < 2) ? 2'h1 : 2'h2);
        end
        acc(1'h1, 4'h0, 32'h0030C010);
        fault_in <= 15'h0;
        pins(2'h2);
        // Current limit on input 7
        fault_in <= 15'h0040;
        acc(1'h1, 4'h0, 32'h7100C004);
        pins(2'h1);
        acc(1'h1, 4'h0, 32'h7000C004);
        pins(2'h2);
        fault_in <= 15'h0;
        acc(1'h1, 4'h0, 32'h7100C004);
        pins(2'h2);
        // Each fault source code picks exactly its own input
        for (i = 1; i < 16; i = i + 1) begin
            fault_in <= 15'h7FFF ^ (15'h1 << (i - 1));
            acc(1'h1, 4'h0, i << 20);
            stat(1'h0);
            fault_in <= 15'h1 << (i - 1);
            stat(1'h1);
        end
        // Locked control register
        acc(1'h1, 4'h0, 32'h0000C000);
        fuse <= 1'h0;
        repeat (4) @(posedge sys_clk);
        acc(1'h1, 4'h0, 32'h0000C002);
        chk_ctrl(32'h0000C000);
        unlock;
        acc(1'h1, 4'h0, 32'h0000C002);
        chk_ctrl(32'h0000C002);
        acc(1'h1, 4'h0, 32'h0000C000);
        chk_ctrl(32'h0000C002);
        acc(1'h1, 4'h4, 32'h0000ABCD);
        acc(1'h0, 4'h8, 32'h0);
        acc(1'h1, 4'h4, 32'h00004321);
        acc(1'h1, 4'h0, 32'h0000C000);
        chk_ctrl(32'h0000C002);
        unlock;
        acc(1'h0, 4'h8, 32'h0);
        `CHK(rd[3:2], 2'h1)
        acc(1'h1, 4'h0, 32'h0000C000);
        chk_ctrl(32'h0000C002);
        acc(1'h0, 4'h4, 32'h0);
        `CHK(rd, 32'h0)
        // Time base starts last; fault data stay untouched from here on
        acc(1'h1, 4'hC, 32'h1);
        acc(1'h0, 4'hC, 32'h0);
        `CHK(rd[0], 1'h1)
        `CHK(tben, 1'h1)
        finish_test;
    end

    // Watchdog, well beyond the expected run
    initial begin
        #400000;
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
endmodule
